/* hdl/gpcn_pkg.sv */
// package: register map, reset values and packet constants of the gpio change-notify port
package gpcn_pkg;
  localparam int GPCN_PINS = 10;
  // printed offsets are word indices; byte address is four times the index
  localparam logic [7:0] GPCN_IDX_DIR = 8'h0D;
  localparam logic [7:0] GPCN_IDX_SET = 8'h0E;
  localparam logic [7:0] GPCN_IDX_CLR = 8'h0F;
  localparam logic [7:0] GPCN_IDX_LVL = 8'h10;
  localparam logic [7:0] GPCN_IDX_MSK = 8'h11;
  localparam logic [7:0] GPCN_IDX_FMT = 8'h12;
  localparam logic [7:0] GPCN_IDX_IST = 8'h20;
  localparam logic [7:0] GPCN_IDX_IEN = 8'h21;
  localparam logic [7:0] GPCN_IDX_ICL = 8'h22;
  localparam logic [9:0] GPCN_DIR_RST = 10'h000;
  localparam logic [9:0] GPCN_MSK_RST = 10'h100;
  localparam logic [1:0] GPCN_FMT_RST = 2'h0;
  localparam int GPCN_FMT_CUSTOM_BIT = 0;
  localparam int GPCN_FMT_BRK_BIT = 1;
  localparam logic [7:0] GPCN_REQ_TYPE = 8'hA1;
  localparam logic [7:0] GPCN_NOTIF_CODE = 8'h20;
  localparam logic [15:0] GPCN_WVALUE = 16'h0000;
  localparam logic [15:0] GPCN_WINDEX = 16'h0000;
  localparam logic [15:0] GPCN_WLENGTH = 16'h0002;
  localparam logic [3:0] GPCN_STD_LEN = 4'hA;
  localparam logic [3:0] GPCN_CUS_LEN = 4'h5;
  // interrupt status bits
  localparam int GPCN_EV_PIN = 0;
  localparam int GPCN_EV_BRK = 1;
  localparam int GPCN_EV_SENT = 2;
  localparam int GPCN_EV_W = 3;
endpackage : gpcn_pkg

/* hdl/gpcn_sync.sv */
// two-flop synchroniser for a bus of asynchronous inputs
`timescale 1ns/10ps
`default_nettype none
module gpcn_sync #(
  parameter int W = 10
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } gpcn_sync_state_type;
  gpcn_sync_state_type st_r;
  gpcn_sync_state_type st_nxt;
  always_comb begin
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign q = st_r.s2;
endmodule // gpcn_sync
`default_nettype wire

/* hdl/gpcn_port.sv */
// gpio port with pin change notification packets, apb register slave
`timescale 1ns/10ps
`default_nettype none
// Operation
// - direction bit set means output, resets input
// - alternate-function pins ignore direction bit
// - set register drives written-one outputs high
// - clear register drives written-one outputs low
// - set/clear only affect general purpose outputs
// - level register reads all ten pins
// - level register write loads output latch
// - unmasked input change sends packet; mask 0x100
// - masking covers gpio and alternate inputs
// - masked pins still reported in levels
// - break enable bit gates break packets
// - format bit selects standard or custom
// - standard packet starts 0xA1 then 0x20
// - then value 0, index 0, length 2
// - standard status bit layout, upper zero
// - custom: levels, change flags, status byte
module gpcn_port
  import gpcn_pkg::*;
#(
  parameter int PINS = gpcn_pkg::GPCN_PINS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [PINS-1:0] pin_in,
  output logic [PINS-1:0] pin_out,
  output logic [PINS-1:0] pin_oe_n,
  input wire logic [PINS-1:0] alt_sel,
  input wire logic [PINS-1:0] alt_out,
  input wire logic [PINS-1:0] alt_oe,
  input wire logic uart_overrun,
  input wire logic uart_parity,
  input wire logic uart_framing,
  input wire logic uart_break_rx,
  input wire logic uart_break_state,
  input wire logic ring,
  input wire logic dsr,
  input wire logic dcd,
  output logic [7:0] pkt_data,
  output logic pkt_valid,
  output logic pkt_last,
  input wire logic pkt_ready,
  output logic irq
);
  import gpcn_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef enum logic [1:0] {
    GPCN_IDLE = 2'b01,
    GPCN_SEND = 2'b10
  } gpcn_fsm_type;

  typedef struct packed {
    logic [PINS-1:0] dir;
    logic [PINS-1:0] latch;
    logic [PINS-1:0] mask;
    logic [1:0] fmt;
    logic [PINS-1:0] prev;
    logic [PINS-1:0] chg;
    logic brk_pend;
    logic pin_pend;
    gpcn_fsm_type fsm;
    logic [3:0] idx;
    logic [3:0] len;
    logic [PINS-1:0] snap_lvl;
    logic [PINS-1:0] snap_chg;
    logic [7:0] snap_stat;
    logic custom;
    logic [GPCN_EV_W-1:0] ist;
    logic [GPCN_EV_W-1:0] ien;
    logic [31:0] rdata;
    logic [2:0] arm;
  } gpcn_state_type;

  gpcn_state_type st_r;
  gpcn_state_type st_nxt;
  logic [PINS-1:0] lvl;
  logic [7:0] idx_a;
  logic wr_en;
  logic rd_en;
  logic [PINS-1:0] gp_out;
  logic [PINS-1:0] in_pins;
  logic [PINS-1:0] diff;
  logic [PINS-1:0] new_chg;
  logic [7:0] std_stat;
  logic [7:0] cus_stat;
  logic [7:0] byte_sel;

  // ----------------------------------------
  // pin synchronisation
  // ----------------------------------------
  gpcn_sync #(.W(PINS)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d(pin_in),
    .q(lvl)
  );

  // ----------------------------------------
  // combinational helpers
  // ----------------------------------------
  assign idx_a = paddr[9:2];
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;
  assign gp_out = st_r.dir & ~alt_sel;
  assign in_pins = ~(gp_out | (alt_sel & alt_oe));
  // reset empties the synchroniser; a pulled-up pin would look like an edge until it fills
  assign diff = (lvl ^ st_r.prev) & in_pins & {PINS{&st_r.arm}};
  assign new_chg = diff & ~st_r.mask;
  assign std_stat = {1'b0, uart_overrun, uart_parity, uart_framing, ring, uart_break_state, dsr, dcd};
  assign cus_stat = {4'h0, uart_overrun, uart_parity, uart_framing, uart_break_state};

  always_comb begin
    byte_sel = 8'h00;
    if (st_r.custom) begin
      case (st_r.idx)
        4'h0: byte_sel = st_r.snap_lvl[7:0];
        4'h1: byte_sel = {6'h00, st_r.snap_lvl[9:8]};
        4'h2: byte_sel = st_r.snap_chg[7:0];
        4'h3: byte_sel = {6'h00, st_r.snap_chg[9:8]};
        4'h4: byte_sel = st_r.snap_stat;
        default: byte_sel = 8'h00;
      endcase
    end else begin
      case (st_r.idx)
        4'h0: byte_sel = GPCN_REQ_TYPE;
        4'h1: byte_sel = GPCN_NOTIF_CODE;
        4'h2: byte_sel = GPCN_WVALUE[7:0];
        4'h3: byte_sel = GPCN_WVALUE[15:8];
        4'h4: byte_sel = GPCN_WINDEX[7:0];
        4'h5: byte_sel = GPCN_WINDEX[15:8];
        4'h6: byte_sel = GPCN_WLENGTH[7:0];
        4'h7: byte_sel = GPCN_WLENGTH[15:8];
        4'h8: byte_sel = st_r.snap_stat;
        4'h9: byte_sel = 8'h00;
        default: byte_sel = 8'h00;
      endcase
    end
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.prev = lvl;
    st_nxt.arm = {st_r.arm[1:0], 1'b1};
    st_nxt.chg = st_r.chg | new_chg;
    if (|new_chg) begin
      st_nxt.pin_pend = 1'b1;
    end
    if (uart_break_rx && st_r.fmt[GPCN_FMT_BRK_BIT]) begin
      st_nxt.brk_pend = 1'b1;
    end
    // register writes, reserved bits dropped
    if (wr_en) begin
      case (idx_a)
        GPCN_IDX_DIR: st_nxt.dir = pwdata[PINS-1:0];
        GPCN_IDX_SET: st_nxt.latch = st_r.latch | (pwdata[PINS-1:0] & gp_out);
        GPCN_IDX_CLR: st_nxt.latch = st_r.latch & ~(pwdata[PINS-1:0] & gp_out);
        GPCN_IDX_LVL: st_nxt.latch = (st_r.latch & ~gp_out) | (pwdata[PINS-1:0] & gp_out);
        GPCN_IDX_MSK: st_nxt.mask = pwdata[PINS-1:0];
        GPCN_IDX_FMT: st_nxt.fmt = pwdata[1:0];
        GPCN_IDX_IEN: st_nxt.ien = pwdata[GPCN_EV_W-1:0];
        default: st_nxt.fmt = st_nxt.fmt;
      endcase
    end
    // packet sequencer
    case (st_r.fsm)
      GPCN_IDLE: begin
        if (st_r.pin_pend || st_r.brk_pend) begin
          st_nxt.fsm = GPCN_SEND;
          st_nxt.idx = 4'h0;
          st_nxt.custom = st_r.fmt[GPCN_FMT_CUSTOM_BIT];
          st_nxt.len = st_r.fmt[GPCN_FMT_CUSTOM_BIT] ? GPCN_CUS_LEN : GPCN_STD_LEN;
          st_nxt.snap_lvl = lvl;
          st_nxt.snap_chg = st_nxt.chg;
          st_nxt.snap_stat = st_r.fmt[GPCN_FMT_CUSTOM_BIT] ? cus_stat : std_stat;
          st_nxt.chg = new_chg;
          st_nxt.pin_pend = |new_chg;
          st_nxt.brk_pend = uart_break_rx && st_r.fmt[GPCN_FMT_BRK_BIT];
          if (st_r.pin_pend) begin
            st_nxt.ist[GPCN_EV_PIN] = 1'b1;
          end
          if (st_r.brk_pend) begin
            st_nxt.ist[GPCN_EV_BRK] = 1'b1;
          end
        end
      end
      GPCN_SEND: begin
        if (pkt_ready) begin
          if (st_r.idx == st_r.len - 4'h1) begin
            st_nxt.fsm = GPCN_IDLE;
            st_nxt.ist[GPCN_EV_SENT] = 1'b1;
          end else begin
            st_nxt.idx = st_r.idx + 4'h1;
          end
        end
      end
      default: st_nxt.fsm = GPCN_IDLE;
    endcase
    // interrupt clear: new events win over the clear
    if (wr_en && idx_a == GPCN_IDX_ICL) begin
      st_nxt.ist = st_nxt.ist & ~(pwdata[GPCN_EV_W-1:0] & ~(st_nxt.ist & ~st_r.ist));
    end
    // read data captured in the setup phase
    if (rd_en) begin
      case (idx_a)
        GPCN_IDX_DIR: st_nxt.rdata = {22'h0, st_r.dir};
        GPCN_IDX_LVL: st_nxt.rdata = {22'h0, lvl};
        GPCN_IDX_MSK: st_nxt.rdata = {22'h0, st_r.mask};
        GPCN_IDX_FMT: st_nxt.rdata = {30'h0, st_r.fmt};
        GPCN_IDX_IST: st_nxt.rdata = {29'h0, st_r.ist};
        GPCN_IDX_IEN: st_nxt.rdata = {29'h0, st_r.ien};
        default: st_nxt.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
      st_r.dir <= GPCN_DIR_RST;
      st_r.mask <= GPCN_MSK_RST;
      st_r.fmt <= GPCN_FMT_RST;
      st_r.fsm <= GPCN_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // pin enable is active low; alternate functions drive through their own path
  assign pin_out = (st_r.latch & gp_out) | (alt_out & alt_sel);
  assign pin_oe_n = ~(gp_out | (alt_sel & alt_oe));
  assign prdata = st_r.rdata;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  // packet bytes change only on an accepted handshake
  assign pkt_data = byte_sel;
  assign pkt_valid = (st_r.fsm == GPCN_SEND);
  assign pkt_last = pkt_valid && (st_r.idx == st_r.len - 4'h1);
  assign irq = |(st_r.ist & st_r.ien);

  // ----------------------------------------
  // checks
  // ----------------------------------------
  AST_DIR_RESET: assert property (@(posedge pclk) $rose(presetn) |-> pin_oe_n == {PINS{1'b1}})
    else $error("pins not inputs after reset");
  AST_ALT_IGNORES_DIR: assert property (@(posedge pclk) disable iff (!presetn)
    (alt_sel & ~alt_oe & ~pin_oe_n) == '0)
    else $error("alternate input pin driven");
  AST_SET_HIGH: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && idx_a == GPCN_IDX_SET |=> ((st_r.latch & $past(pwdata[PINS-1:0] & gp_out)) == $past(pwdata[PINS-1:0] & gp_out)))
    else $error("set write did not raise output");
  AST_CLR_LOW: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && idx_a == GPCN_IDX_CLR |=> ((st_r.latch & $past(pwdata[PINS-1:0] & gp_out)) == '0))
    else $error("clear write did not lower output");
  AST_SET_INPUT_KEEP: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && (idx_a == GPCN_IDX_SET || idx_a == GPCN_IDX_CLR)
    |=> ((st_r.latch ^ $past(st_r.latch)) & ~$past(gp_out)) == '0)
    else $error("set or clear touched an input");
  AST_LVL_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && idx_a == GPCN_IDX_LVL |=> ((st_r.latch ^ $past(pwdata[PINS-1:0])) & $past(gp_out)) == '0)
    else $error("level write not loaded");
  AST_LVL_READ: assert property (@(posedge pclk) disable iff (!presetn)
    rd_en && idx_a == GPCN_IDX_LVL |=> prdata == {22'h0, $past(lvl)})
    else $error("level read wrong");
  AST_PKT_START: assert property (@(posedge pclk) disable iff (!presetn)
    st_r.fsm == GPCN_IDLE && st_r.pin_pend |=> pkt_valid)
    else $error("pending change sent no packet");
  AST_STD_HEAD: assert property (@(posedge pclk) disable iff (!presetn)
    pkt_valid && !st_r.custom && st_r.idx == 4'h0 |-> pkt_data == GPCN_REQ_TYPE)
    else $error("bad request type byte");
  AST_STD_LEN: assert property (@(posedge pclk) disable iff (!presetn)
    pkt_valid && !st_r.custom && st_r.idx == 4'h6 |-> pkt_data == 8'h02)
    else $error("bad length byte");
  AST_STD_STAT: assert property (@(posedge pclk) disable iff (!presetn)
    pkt_valid && !st_r.custom && st_r.idx == 4'h8 |-> !pkt_data[7])
    else $error("reserved status bit set");
  AST_CUS_LAST: assert property (@(posedge pclk) disable iff (!presetn)
    pkt_last && st_r.custom |-> st_r.idx == 4'h4 && pkt_data[7:4] == 4'h0)
    else $error("custom packet length wrong");
  AST_BRK_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    !st_r.fmt[GPCN_FMT_BRK_BIT] && !st_r.brk_pend |=> !st_r.brk_pend)
    else $error("break pended while disabled");
  AST_RSVD_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    prdata[31:PINS] == '0)
    else $error("reserved read bits nonzero");

  // ----------------------------------------
  // packet and masking checks
  // ----------------------------------------
  // byte map pinned here so a shifted field shows up without a host model
  AST_STD_CODE: assert property (@(posedge pclk) disable iff (!presetn)
    pkt_valid && !st_r.custom && st_r.idx == 4'h1 |-> pkt_data == GPCN_NOTIF_CODE)
    else $error("bad notification code byte");
  AST_STD_PAD: assert property (@(posedge pclk) disable iff (!presetn)
    pkt_valid && !st_r.custom && st_r.idx == 4'h9 |-> pkt_data == 8'h00)
    else $error("upper status byte not zero");
  AST_CUS_LVL_HI: assert property (@(posedge pclk) disable iff (!presetn)
    pkt_valid && st_r.custom && st_r.idx == 4'h1 |-> pkt_data[7:2] == 6'h00)
    else $error("custom level high byte has stray bits");
  AST_CUS_HEAD: assert property (@(posedge pclk) disable iff (!presetn)
    st_r.fsm == GPCN_IDLE && (st_r.pin_pend || st_r.brk_pend) && st_r.fmt[GPCN_FMT_CUSTOM_BIT]
    |=> pkt_valid && pkt_data == $past(lvl[7:0]))
    else $error("custom packet lost pin levels");
  AST_FMT_LATCH: assert property (@(posedge pclk) disable iff (!presetn)
    st_r.fsm == GPCN_IDLE && (st_r.pin_pend || st_r.brk_pend)
    |=> st_r.custom == $past(st_r.fmt[GPCN_FMT_CUSTOM_BIT]))
    else $error("packet format not taken from format bit");
  AST_BRK_ON: assert property (@(posedge pclk) disable iff (!presetn)
    uart_break_rx && st_r.fmt[GPCN_FMT_BRK_BIT] |=> st_r.brk_pend)
    else $error("enabled break not pended");
  AST_MASK_BLOCKS: assert property (@(posedge pclk) disable iff (!presetn)
    !st_r.pin_pend && ((lvl ^ st_r.prev) & in_pins & ~st_r.mask) == '0 |=> !st_r.pin_pend)
    else $error("masked change pended a packet");
  AST_PKT_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    pkt_valid && !pkt_ready |=> pkt_valid && $stable(pkt_data))
    else $error("packet byte moved before acceptance");
  AST_ARM_QUIET: assert property (@(posedge pclk) disable iff (!presetn)
    !(&st_r.arm) |=> !st_r.pin_pend)
    else $error("change seen before synchroniser filled");
  COV_STD: cover property (@(posedge pclk) pkt_last && !st_r.custom && pkt_ready);
  COV_CUS: cover property (@(posedge pclk) pkt_last && st_r.custom && pkt_ready);
  COV_BRK: cover property (@(posedge pclk) st_r.brk_pend ##1 pkt_valid);
  COV_IRQ: cover property (@(posedge pclk) $rose(irq));
  COV_QUEUED: cover property (@(posedge pclk) pkt_last && pkt_ready && (st_r.pin_pend || st_r.brk_pend));
endmodule // gpcn_port
`default_nettype wire

/* bench/gpcn_host_sink.sv */
// host-side packet sink that collects notification bytes, optionally stalling
`timescale 1ns/10ps
`default_nettype none
module gpcn_host_sink (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] pkt_data,
  input wire logic pkt_valid,
  input wire logic pkt_last,
  output logic pkt_ready,
  input wire logic stall,
  input wire logic clr
);
  logic [7:0] got [0:15];
  int count;
  int last_at;
  // ----------------------------------------
  // byte capture
  // ----------------------------------------
  // a slow host takes a byte only every other cycle while stalling
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pkt_ready <= 1'b0;
      count <= 0;
      last_at <= 0;
    end else if (clr) begin
      count <= 0;
      last_at <= 0;
    end else begin
      pkt_ready <= stall ? ~pkt_ready : 1'b1;
      if (pkt_valid && pkt_ready && count < 16) begin
        got[count] <= pkt_data;
        count <= count + 1;
        if (pkt_last) begin
          last_at <= count + 1;
        end
      end
    end
  end
endmodule // gpcn_host_sink
`default_nettype wire

/* bench/gpcn_port_tb.sv */
// self-checking testbench of the gpio change-notify port
`timescale 1ns/10ps
`default_nettype none
module gpcn_port_tb;
  import gpcn_pkg::*;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr, irq, stall, clr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic [9:0] pin_in, pin_out, pin_oe_n, alt_sel, alt_out, alt_oe;
  logic uart_overrun, uart_parity, uart_framing, uart_break_rx, uart_break_state, ring, dsr, dcd;
  logic [7:0] pkt_data;
  logic pkt_valid, pkt_last, pkt_ready;
  int bad_count = 0;
  int checked = 0;
  logic [7:0] std_exp [0:9] = '{8'hA1, 8'h20, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h76, 8'h00};
  always #25 pclk = ~pclk;
  gpcn_port uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .alt_sel(alt_sel), .alt_out(alt_out), .alt_oe(alt_oe),
    .uart_overrun(uart_overrun), .uart_parity(uart_parity), .uart_framing(uart_framing),
    .uart_break_rx(uart_break_rx), .uart_break_state(uart_break_state), .ring(ring), .dsr(dsr), .dcd(dcd),
    .pkt_data(pkt_data), .pkt_valid(pkt_valid), .pkt_last(pkt_last), .pkt_ready(pkt_ready), .irq(irq));
  gpcn_host_sink host (.pclk(pclk), .presetn(presetn), .pkt_data(pkt_data), .pkt_valid(pkt_valid),
    .pkt_last(pkt_last), .pkt_ready(pkt_ready), .stall(stall), .clr(clr));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdata = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    // the write landed at the previous edge; callers look at outputs only once it has settled
    @(posedge pclk);
  endtask
  task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk(rdata, exp);
  endtask
  // waits bounded, then lets extra bytes show up before counting
  task automatic wait_bytes(input int n);
    for (int k = 0; k < 300 && host.count < n; k++) @(posedge pclk);
    repeat (20) @(posedge pclk);
    chk(32'(host.count), 32'(n));
  endtask
  task automatic flush;
    clr <= 1'b1;
    @(posedge pclk);
    clr <= 1'b0;
  endtask
  task automatic pulse_break;
    uart_break_rx <= 1'b1;
    @(posedge pclk);
    uart_break_rx <= 1'b0;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    rdc(GPCN_IDX_DIR, 32'h0);
    rdc(GPCN_IDX_MSK, 32'h100);
    rdc(GPCN_IDX_FMT, 32'h0);
    chk(32'(pin_oe_n), 32'h3FF);
    $display("test reset done");
  endtask
  task automatic t_drive;
    apb(1'b1, GPCN_IDX_MSK, 32'h3FF);
    apb(1'b1, GPCN_IDX_DIR, 32'hFFFF_F00F);
    rdc(GPCN_IDX_DIR, 32'h00F);
    apb(1'b1, GPCN_IDX_SET, 32'h3FF);
    chk(32'(pin_oe_n), 32'h3F2);
    chk(32'(pin_out[3:0]), 32'hD);
    apb(1'b1, GPCN_IDX_CLR, 32'h005);
    chk(32'(pin_out[3:0]), 32'h8);
    apb(1'b1, GPCN_IDX_DIR, 32'h01F);
    chk(32'(pin_out[4]), 32'h0);
    apb(1'b1, GPCN_IDX_LVL, 32'h3F6);
    chk(32'(pin_out[4:0]), 32'h14);
    apb(1'b1, GPCN_IDX_SET, 32'h001);
    chk(32'(pin_out[4:0]), 32'h15);
    $display("test drive done");
  endtask
  task automatic t_level;
    pin_in <= 10'h2A5;
    repeat (4) @(posedge pclk);
    rdc(GPCN_IDX_LVL, 32'h2A5);
    $display("test level done");
  endtask
  task automatic t_std;
    apb(1'b1, GPCN_IDX_IEN, 32'h1);
    apb(1'b1, GPCN_IDX_MSK, 32'h3DF);
    stall <= 1'b1;
    flush();
    pin_in <= 10'h285;
    wait_bytes(10);
    chk(32'(host.last_at), 32'd10);
    for (int i = 0; i < 10; i++) chk(32'(host.got[i]), 32'(std_exp[i]));
    chk(32'(irq), 32'h1);
    rdc(GPCN_IDX_IST, 32'h5);
    apb(1'b1, GPCN_IDX_ICL, 32'h7);
    chk(32'(irq), 32'h0);
    rdc(8'h3F, 32'h0);
    chk(32'(pslverr), 32'h0);
    stall <= 1'b0;
    $display("test standard packet done");
  endtask
  task automatic t_custom;
    flush();
    pin_in <= 10'h185;
    wait_bytes(0);
    apb(1'b1, GPCN_IDX_FMT, 32'h1);
    pulse_break();
    wait_bytes(0);
    apb(1'b1, GPCN_IDX_FMT, 32'h3);
    pulse_break();
    wait_bytes(5);
    chk({host.got[0], host.got[1], host.got[4]}, 32'h85010F);
    apb(1'b1, GPCN_IDX_MSK, 32'h3FD);
    flush();
    pin_in <= 10'h187;
    wait_bytes(5);
    chk({host.got[0], host.got[2], host.got[3]}, 32'h870200);
    $display("test custom packet done");
  endtask
  // ----------------------------------------
  // run control
  // ----------------------------------------
  task automatic close_out;
    $display("checked %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // status levels stay put so that every packet of one format carries the same status byte (0x76 standard, 0x0F custom)
  initial begin
    {presetn, psel, penable, pwrite, stall, clr, uart_break_rx} = '0;
    {paddr, pwdata, pin_in, alt_out, alt_oe} = '0;
    alt_sel = 10'h002;
    {uart_overrun, uart_parity, uart_framing, uart_break_state, ring, dsr, dcd} = 7'b1111010;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_drive();
    t_level();
    t_std();
    t_custom();
    close_out();
  end
  initial begin
    #2000000;
    bad_count++;
    $display("mismatch at %0t: watchdog expired", $time);
    close_out();
  end
endmodule // gpcn_port_tb
`default_nettype wire
